//--- inc/marb_pkg.sv
package marb_pkg;

   // Bus geometry
   localparam int DATA_W = 32;
   localparam int ADDR_W = 14;

   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_SCALE = 12'h476;
   localparam logic [11:0] IDX_SUPPLY = 12'h478;
   localparam logic [11:0] IDX_PHASE_A = 12'h47e;
   localparam logic [11:0] IDX_PHASE_B = 12'h480;
   localparam logic [11:0] IDX_PHASE_C = 12'h482;
   localparam logic [11:0] IDX_SINE = 12'h4ba;
   localparam logic [11:0] IDX_COSINE = 12'h4bc;
   localparam logic [11:0] IDX_CTRL = 12'h4c0;
   localparam logic [11:0] IDX_STATUS = 12'h4c2;

   localparam logic [ADDR_W-1:0] ADDR_SCALE = {IDX_SCALE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_SUPPLY = {IDX_SUPPLY, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_PHASE_A = {IDX_PHASE_A, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_PHASE_B = {IDX_PHASE_B, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_PHASE_C = {IDX_PHASE_C, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_SINE = {IDX_SINE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_COSINE = {IDX_COSINE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

   // Storage slots of the readback bank
   localparam int NUM_SLOTS = 7;
   localparam int SLOT_SCALE = 0;
   localparam int SLOT_SUPPLY = 1;
   localparam int SLOT_PHASE_A = 2;
   localparam int SLOT_PHASE_B = 3;
   localparam int SLOT_PHASE_C = 4;
   localparam int SLOT_SINE = 5;
   localparam int SLOT_COSINE = 6;

   // Full-scale voltage codes and fixed-point scaling
   localparam logic [15:0] SCALE_CODE_60V = 16'h0000;
   localparam logic [15:0] SCALE_CODE_30V = 16'h0001;
   localparam logic [15:0] SCALE_CODE_15V = 16'h0002;
   localparam logic [15:0] SCALE_RSVD_ZERO = 16'h0000;
   localparam int FRAC_BITS = 27;
   localparam int FULL_SCALE_VOLTS = 60;

   // Reset values and control fields
   localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
   localparam int CTRL_FREEZE_BIT = 0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   typedef struct packed {
      logic [DATA_W-1:0] phase_a;
      logic [DATA_W-1:0] phase_b;
      logic [DATA_W-1:0] phase_c;
   } marb_phase_t;

   typedef struct packed {
      logic [DATA_W-1:0] sine;
      logic [DATA_W-1:0] cosine;
   } marb_angle_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } marb_rd_state_t;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP = 2'b10
   } marb_wr_state_t;

   // Any address the bank answers with OKAY
   function automatic logic marb_mapped(input logic [ADDR_W-1:0] addr);
      logic hit;
      hit = 1'b0;
      case (addr)
         ADDR_SCALE, ADDR_SUPPLY, ADDR_PHASE_A, ADDR_PHASE_B, ADDR_PHASE_C,
         ADDR_SINE, ADDR_COSINE, ADDR_CTRL, ADDR_STATUS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

endpackage

//--- verilog/marb_hold_reg.sv
`timescale 1ns/1ps
`default_nettype none

// Holding register: clears on reset, loads only on its strobe
module marb_hold_reg import marb_pkg::*; #(
   parameter int WIDTH = DATA_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Load side
   input wire logic load,
   input wire logic [WIDTH-1:0] d,
   // Held value
   output logic [WIDTH-1:0] q
);

   // Value stays put between loads; bus writes never reach here
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         q <= '0;
      end else if (load) begin
         q <= d;
      end
   end

endmodule

`default_nettype wire

//--- verilog/marb_axil_wr.sv
`timescale 1ns/1ps
`default_nettype none

// AXI4-Lite write side: address and data in either order, then one response
module marb_axil_wr import marb_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Write address channel
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data channel
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Accepted write towards the bank
   output logic wr_pulse,
   output logic [ADDR_W-1:0] wr_addr,
   output logic [DATA_W-1:0] wr_data,
   output logic [3:0] wr_strb
);

   marb_wr_state_t state_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] data_reg;
   logic [3:0] strb_reg;
   logic aw_fire;
   logic w_fire;
   logic aw_have;
   logic w_have;
   logic [ADDR_W-1:0] eff_addr;

   // Handshakes and the address seen when both halves are present
   assign aw_fire = s_axi_awvalid & s_axi_awready;
   assign w_fire = s_axi_wvalid & s_axi_wready;
   assign aw_have = aw_held_reg | aw_fire;
   assign w_have = w_held_reg | w_fire;
   assign eff_addr = aw_held_reg ? addr_reg : s_axi_awaddr;

   // Capture each half as it arrives
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         addr_reg <= '0;
         data_reg <= RESET_WORD;
         strb_reg <= 4'h0;
      end else begin
         if (aw_fire) begin
            addr_reg <= s_axi_awaddr;
         end
         if (w_fire) begin
            data_reg <= s_axi_wdata;
            strb_reg <= s_axi_wstrb;
         end
      end
   end

   // Collect, then answer; readies drop so only one write is in flight
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg <= WR_COLLECT;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         wr_pulse <= 1'b0;
         wr_addr <= '0;
         wr_data <= RESET_WORD;
         wr_strb <= 4'h0;
      end else begin
         wr_pulse <= 1'b0;
         case (state_reg)
            WR_COLLECT: begin
               if (aw_have && w_have) begin
                  state_reg <= WR_RESP;
                  aw_held_reg <= 1'b0;
                  w_held_reg <= 1'b0;
                  s_axi_awready <= 1'b0;
                  s_axi_wready <= 1'b0;
                  s_axi_bvalid <= 1'b1;
                  // Writes to the readback words are accepted but change nothing
                  s_axi_bresp <= marb_mapped(eff_addr) ? RESP_OKAY : RESP_DECERR;
                  wr_pulse <= 1'b1;
                  wr_addr <= eff_addr;
                  wr_data <= w_held_reg ? data_reg : s_axi_wdata;
                  wr_strb <= w_held_reg ? strb_reg : s_axi_wstrb;
               end else begin
                  aw_held_reg <= aw_have;
                  w_held_reg <= w_have;
                  s_axi_awready <= ~aw_have;
                  s_axi_wready <= ~w_have;
               end
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  state_reg <= WR_COLLECT;
                  s_axi_bvalid <= 1'b0;
                  s_axi_awready <= 1'b1;
                  s_axi_wready <= 1'b1;
               end
            end
            default: begin
               state_reg <= WR_COLLECT;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

//--- verilog/marb_top.sv
`timescale 1ns/1ps
`default_nettype none

module marb_top import marb_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Algorithm updates, same clock
   input wire logic scale_upd,
   input wire logic [15:0] scale_code,
   input wire logic supply_upd,
   input wire logic [DATA_W-1:0] supply_word,
   input wire logic initial_speed_detect_capture,
   input wire marb_phase_t phase_words,
   input wire logic angle_upd,
   input wire marb_angle_t angle_words
);

   logic wr_pulse;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [3:0] wr_strb;
   logic freeze_reg;
   logic [NUM_SLOTS-1:0] seen_reg;
   logic scale_ok;
   logic [NUM_SLOTS-1:0] slot_load;
   logic [DATA_W-1:0] slot_d [NUM_SLOTS];
   logic [DATA_W-1:0] slot_q [NUM_SLOTS];
   marb_rd_state_t rd_state_reg;
   logic [DATA_W-1:0] rd_data_next;
   logic [1:0] rd_resp_next;
   logic ar_fire;

   // Write channels live in their own module
   marb_axil_wr u_wr (
      .clk_sys(clk_sys),
      .reset(reset),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .wr_pulse(wr_pulse),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb)
   );

   // Control word: freeze lets software read a coherent snapshot
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         freeze_reg <= 1'b0;
      end else if (wr_pulse && wr_addr == ADDR_CTRL && wr_strb[0]) begin
         freeze_reg <= wr_data[CTRL_FREEZE_BIT];
      end
   end

   // Only the three documented codes are taken; anything else is dropped
   assign scale_ok = (scale_code == SCALE_CODE_60V) || (scale_code == SCALE_CODE_30V) ||
                     (scale_code == SCALE_CODE_15V);

   // Load strobes; bus data has no path into the bank, only the bus-written freeze bit gates them
   always_comb begin
      slot_load = '0;
      slot_load[SLOT_SCALE] = scale_upd & scale_ok & ~freeze_reg;
      slot_load[SLOT_SUPPLY] = supply_upd & ~freeze_reg;
      slot_load[SLOT_PHASE_A] = initial_speed_detect_capture & ~freeze_reg;
      slot_load[SLOT_PHASE_B] = initial_speed_detect_capture & ~freeze_reg;
      slot_load[SLOT_PHASE_C] = initial_speed_detect_capture & ~freeze_reg;
      slot_load[SLOT_SINE] = angle_upd & ~freeze_reg;
      slot_load[SLOT_COSINE] = angle_upd & ~freeze_reg;
   end

   // Load data; words pass through unchanged, scaling is the producer's
   always_comb begin
      slot_d[SLOT_SCALE] = {SCALE_RSVD_ZERO, scale_code};
      slot_d[SLOT_SUPPLY] = supply_word;
      slot_d[SLOT_PHASE_A] = phase_words.phase_a;
      slot_d[SLOT_PHASE_B] = phase_words.phase_b;
      slot_d[SLOT_PHASE_C] = phase_words.phase_c;
      slot_d[SLOT_SINE] = angle_words.sine;
      slot_d[SLOT_COSINE] = angle_words.cosine;
   end

   // One holding register per readback word
   generate
      for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
         marb_hold_reg #(.WIDTH(DATA_W)) u_hold (
            .clk_sys(clk_sys),
            .reset(reset),
            .load(slot_load[i]),
            .d(slot_d[i]),
            .q(slot_q[i])
         );
      end
   endgenerate

   // Sticky record of which words have been loaded since reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         seen_reg <= '0;
      end else begin
         seen_reg <= seen_reg | slot_load;
      end
   end

   // Read decode
   always_comb begin
      rd_data_next = RESET_WORD;
      rd_resp_next = RESP_OKAY;
      case (s_axi_araddr)
         ADDR_SCALE: rd_data_next = slot_q[SLOT_SCALE];
         ADDR_SUPPLY: rd_data_next = slot_q[SLOT_SUPPLY];
         ADDR_PHASE_A: rd_data_next = slot_q[SLOT_PHASE_A];
         ADDR_PHASE_B: rd_data_next = slot_q[SLOT_PHASE_B];
         ADDR_PHASE_C: rd_data_next = slot_q[SLOT_PHASE_C];
         ADDR_SINE: rd_data_next = slot_q[SLOT_SINE];
         ADDR_COSINE: rd_data_next = slot_q[SLOT_COSINE];
         ADDR_CTRL: rd_data_next = {{(DATA_W-1){1'b0}}, freeze_reg};
         ADDR_STATUS: rd_data_next = {{(DATA_W-NUM_SLOTS){1'b0}}, seen_reg};
         default: rd_resp_next = RESP_DECERR;
      endcase
   end

   assign ar_fire = s_axi_arvalid & s_axi_arready;

   // Read channel: data is latched at acceptance, so it cannot tear
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_state_reg <= RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= RESET_WORD;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         case (rd_state_reg)
            RD_IDLE: begin
               s_axi_arready <= 1'b1;
               if (ar_fire) begin
                  rd_state_reg <= RD_RESP;
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= rd_data_next;
                  s_axi_rresp <= rd_resp_next;
               end
            end
            RD_RESP: begin
               if (s_axi_rready) begin
                  rd_state_reg <= RD_IDLE;
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
               end
            end
            default: begin
               rd_state_reg <= RD_IDLE;
               s_axi_rvalid <= 1'b0;
            end
         endcase
      end
   end

   // Checks on the bank contents and the read channel
   AST_SCALE_CODE_RANGE: assert property (@(posedge clk_sys) disable iff (reset)
      slot_q[SLOT_SCALE][15:0] <= SCALE_CODE_15V)
      else $error("scale code outside 0..2");

   AST_SCALE_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (reset)
      s_axi_rvalid && $past(s_axi_araddr) == ADDR_SCALE && $rose(s_axi_rvalid)
      |-> s_axi_rdata[31:16] == SCALE_RSVD_ZERO)
      else $error("scale upper half read nonzero");

   AST_SUPPLY_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
      supply_upd && !freeze_reg |=> slot_q[SLOT_SUPPLY] == $past(supply_word))
      else $error("supply word not loaded");

   AST_PHASE_A_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
      initial_speed_detect_capture && !freeze_reg
      |=> slot_q[SLOT_PHASE_A] == $past(phase_words.phase_a))
      else $error("phase A word not captured");

   AST_PHASE_B_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
      !initial_speed_detect_capture |=> $stable(slot_q[SLOT_PHASE_B]))
      else $error("phase B word moved outside capture");

   AST_PHASE_C_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
      initial_speed_detect_capture && !freeze_reg
      |=> slot_q[SLOT_PHASE_C] == $past(phase_words.phase_c))
      else $error("phase C word not captured");

   AST_ANGLE_PAIR: assert property (@(posedge clk_sys) disable iff (reset)
      angle_upd && !freeze_reg |=> slot_q[SLOT_SINE] == $past(angle_words.sine)
      && slot_q[SLOT_COSINE] == $past(angle_words.cosine))
      else $error("angle words not loaded together");

   // Checked the edge after a reset cycle; avoids leaning on a history before the first edge
   AST_RESET_ZERO: assert property (@(posedge clk_sys)
      reset |=> slot_q[SLOT_SUPPLY] == RESET_WORD && slot_q[SLOT_SINE] == RESET_WORD
      && slot_q[SLOT_SCALE] == RESET_WORD && slot_q[SLOT_PHASE_A] == RESET_WORD
      && seen_reg == '0)
      else $error("bank not cleared by reset");

   AST_WRITE_IGNORED: assert property (@(posedge clk_sys) disable iff (reset)
      wr_pulse && !supply_upd |=> $stable(slot_q[SLOT_SUPPLY]))
      else $error("bus write changed a readback word");

   AST_READ_LATENCY: assert property (@(posedge clk_sys) disable iff (reset)
      ar_fire |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one cycle after acceptance");

   // Main scenarios
   COV_CAPTURE_THEN_READ: cover property (@(posedge clk_sys) disable iff (reset)
      initial_speed_detect_capture ##[1:20] (ar_fire && s_axi_araddr == ADDR_PHASE_A));
   COV_FROZEN_UPDATE: cover property (@(posedge clk_sys) disable iff (reset)
      freeze_reg && angle_upd);
   COV_WRITE_READONLY: cover property (@(posedge clk_sys) disable iff (reset)
      wr_pulse && wr_addr == ADDR_SUPPLY);
   COV_UNMAPPED_READ: cover property (@(posedge clk_sys) disable iff (reset)
      s_axi_rvalid && s_axi_rresp == RESP_DECERR);

endmodule

`default_nettype wire

//--- test/marb_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module marb_top_bench import marb_pkg::*; ();
   localparam int LIMIT = 200;
   localparam logic [ADDR_W-1:0] WADDR [7] = '{ADDR_SCALE, ADDR_SUPPLY, ADDR_PHASE_A,
      ADDR_PHASE_B, ADDR_PHASE_C, ADDR_SINE, ADDR_COSINE};
   logic clk_sys;
   logic reset;
   logic [ADDR_W-1:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [DATA_W-1:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [ADDR_W-1:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [DATA_W-1:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   logic scale_upd;
   logic [15:0] scale_code;
   logic supply_upd;
   logic [DATA_W-1:0] supply_word;
   logic initial_speed_detect_capture;
   marb_phase_t phase_words;
   logic angle_upd;
   marb_angle_t angle_words;
   int err_count;
   int n_checks;
   // Words software should see, kept from what was loaded
   logic [DATA_W-1:0] exp_w [7];

   marb_top u_dut (.clk_sys(clk_sys), .reset(reset),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scale_upd(scale_upd),
      .scale_code(scale_code), .supply_upd(supply_upd), .supply_word(supply_word),
      .initial_speed_detect_capture(initial_speed_detect_capture), .phase_words(phase_words),
      .angle_upd(angle_upd), .angle_words(angle_words));

   // 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic results();
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t data %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t response %b expected %b", $time, got, exp);
      end
   endtask

   // A bound that runs out ends the run at once
   task automatic give_up(input int n);
      if (n >= LIMIT) begin
         err_count++;
         $display("[FAIL] %0t handshake timed out", $time);
         results();
      end
   endtask

   // Address and data offered together, each released when taken
   task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                            output logic [1:0] r);
      int n;
      logic aw_done;
      logic w_done;
      n = 0;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done) && n < LIMIT) begin
         @(posedge clk_sys);
         n++;
         if (!aw_done && s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1 && n < LIMIT) begin
         @(posedge clk_sys);
         n++;
      end
      give_up(n);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                           output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (s_axi_arready !== 1'b1 && n < LIMIT);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1 && n < LIMIT) begin
         @(posedge clk_sys);
         n++;
      end
      give_up(n);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Read one word and expect it with an OKAY answer
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      chk_data(d, exp);
      chk_resp(r, RESP_OKAY);
   endtask

   // One-cycle algorithm strobe: 0 scale, 1 supply, 2 phase capture, 3 angle
   task automatic strobe(input int k);
      @(posedge clk_sys);
      case (k)
         0: scale_upd <= 1'b1;
         1: supply_upd <= 1'b1;
         2: initial_speed_detect_capture <= 1'b1;
         default: angle_upd <= 1'b1;
      endcase
      @(posedge clk_sys);
      scale_upd <= 1'b0;
      supply_upd <= 1'b0;
      initial_speed_detect_capture <= 1'b0;
      angle_upd <= 1'b0;
   endtask

   task automatic do_reset();
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      foreach (exp_w[j]) exp_w[j] = RESET_WORD;
   endtask

   initial begin
      logic [DATA_W-1:0] d;
      logic [1:0] r;
      logic [15:0] codes [3];
      codes = '{SCALE_CODE_60V, SCALE_CODE_30V, SCALE_CODE_15V};
      err_count = 0;
      n_checks = 0;
      reset = 1'b1;
      s_axi_awaddr = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = '0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      scale_upd = 1'b0;
      scale_code = 16'h0000;
      supply_upd = 1'b0;
      supply_word = '0;
      initial_speed_detect_capture = 1'b0;
      phase_words = '0;
      angle_upd = 1'b0;
      angle_words = '0;
      do_reset();
      // Everything reads zero out of reset, status too
      foreach (WADDR[i]) rd_chk(WADDR[i], RESET_WORD);
      rd_chk(ADDR_STATUS, RESET_WORD);
      // Each full-scale code, upper half must stay clear
      foreach (codes[i]) begin
         scale_code <= codes[i];
         strobe(0);
         rd_chk(ADDR_SCALE, {16'h0000, codes[i]});
      end
      // An undefined code is dropped, last good one stays
      scale_code <= 16'h0003;
      strobe(0);
      rd_chk(ADDR_SCALE, {16'h0000, SCALE_CODE_15V});
      exp_w[SLOT_SCALE] = {16'h0000, SCALE_CODE_15V};
      // 24 V bus is 24/60 of two to the 27
      supply_word <= 32'h0333_3333;
      strobe(1);
      exp_w[SLOT_SUPPLY] = 32'h0333_3333;
      rd_chk(ADDR_SUPPLY, exp_w[SLOT_SUPPLY]);
      // Phases captured together, distinct values catch swaps
      phase_words <= '{phase_a: 32'h0123_4567, phase_b: 32'h89ab_cdef, phase_c: 32'hfedc_ba98};
      strobe(2);
      exp_w[SLOT_PHASE_A] = 32'h0123_4567;
      exp_w[SLOT_PHASE_B] = 32'h89ab_cdef;
      exp_w[SLOT_PHASE_C] = 32'hfedc_ba98;
      rd_chk(ADDR_PHASE_A, exp_w[SLOT_PHASE_A]);
      rd_chk(ADDR_PHASE_B, exp_w[SLOT_PHASE_B]);
      rd_chk(ADDR_PHASE_C, exp_w[SLOT_PHASE_C]);
      // Sine of minus unity and cosine of unity
      angle_words <= '{sine: 32'hf800_0000, cosine: 32'h0800_0000};
      strobe(3);
      exp_w[SLOT_SINE] = 32'hf800_0000;
      exp_w[SLOT_COSINE] = 32'h0800_0000;
      rd_chk(ADDR_SINE, exp_w[SLOT_SINE]);
      rd_chk(ADDR_COSINE, exp_w[SLOT_COSINE]);
      rd_chk(ADDR_STATUS, 32'h0000_007f);
      // Writes to readback words answer OKAY and change nothing
      foreach (WADDR[i]) begin
         axi_write(WADDR[i], ~exp_w[i], r);
         chk_resp(r, RESP_OKAY);
         rd_chk(WADDR[i], exp_w[i]);
      end
      // Unmapped place is refused both ways
      axi_read(14'h0004, d, r);
      chk_data(d, RESET_WORD);
      chk_resp(r, RESP_DECERR);
      axi_write(14'h0004, 32'h0000_0001, r);
      chk_resp(r, RESP_DECERR);
      // Freeze holds the bank, release lets updates through
      axi_write(ADDR_CTRL, 32'h0000_0001, r);
      chk_resp(r, RESP_OKAY);
      rd_chk(ADDR_CTRL, 32'h0000_0001);
      supply_word <= 32'h0555_5555;
      strobe(1);
      rd_chk(ADDR_SUPPLY, exp_w[SLOT_SUPPLY]);
      axi_write(ADDR_CTRL, 32'h0000_0000, r);
      chk_resp(r, RESP_OKAY);
      rd_chk(ADDR_CTRL, RESET_WORD);
      strobe(1);
      rd_chk(ADDR_SUPPLY, 32'h0555_5555);
      // A second reset clears every word again
      do_reset();
      foreach (WADDR[i]) rd_chk(WADDR[i], RESET_WORD);
      rd_chk(ADDR_STATUS, RESET_WORD);
      results();
   end
endmodule

`default_nettype wire
